// [hdl/awg_top.sv]
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "awg_map.svh"
module awg_top (
   input  wire logic        aclk,           // 250 mhz clock
   input  wire logic        aresetn,        // sync reset, active low
   input  wire logic [7:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // write strobes
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // write response ready
   input  wire logic [7:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read data valid
   input  wire logic        s_axi_rready,   // read data ready
   input  wire logic [15:0] capt_sample,    // captured waveform sample
   input  wire logic [7:0]  capt_addr,      // captured sample index
   input  wire logic        capt_valid,     // captured sample strobe
   input  wire logic [7:0]  capt_count,     // captured sample count
   output logic [15:0]      generator_one,  // converter code, generator one
   output logic [15:0]      generator_two,  // converter code, generator two
   output logic [1:0]       gen_drive       // output connector enables
);
   localparam int D = `AWG_DEPTH;

   function automatic logic [15:0] scale(input logic [15:0] s, input logic [15:0] g);
      logic [31:0] p;
      p = 32'(signed'(s)) * 32'(g);
      return p[23:8];
   endfunction

   function automatic logic [31:0] cfg_word(input awg_pkg::awg_cfg_t c);
      return {29'h0, c.out_en, c.src_saved, c.run_single};  // out_en b2, source b1, mode b0
   endfunction

   // bus state
   awg_pkg::awg_bus_t st_q, st_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic        aw_got_q, aw_got_d, w_got_q, w_got_d, ws_q, ws_d;
   logic [4:0]  hs_q, hs_d;  // rvalid, bvalid, arready, wready, awready

   // control state
   awg_pkg::awg_cfg_t cfg_q[2], cfg_d[2];
   awg_pkg::awg_par_t par_q[2], par_d[2];
   logic [15:0] phase_q, phase_d;
   logic [4:0]  sync_q, sync_d;
   logic [15:0] mem_q[2][D], mem_d[2][D];
   logic [8:0]  nsamp_q[2], nsamp_d[2];
   logic [15:0] lvl_q[2], lvl_d[2];
   logic [8:0]  idx_q[2], idx_d[2];
   logic [15:0] div_q[2], div_d[2];
   logic [1:0]  play_q, play_d;
   logic [1:0]  once_q, once_d;
   logic [1:0]  lderr_q, lderr_d;
   logic [15:0] out_q[2], out_d[2];
   logic [1:0]  drv_q, drv_d;

   logic        wr_fire, rd_fire;
   logic [31:0] wv;
   logic [1:0]  trig, single_req;
   logic        coupled, sync_on;
   awg_pkg::awg_par_t eff[2];

   assign wr_fire = (st_q == awg_pkg::ST_WR);
   assign wv      = wd_q;
   assign coupled = sync_q[`AWG_S_CPL_EN] &
                    (sync_q[`AWG_S_CPL_FREQ] | sync_q[`AWG_S_CPL_AMPL]);
   assign sync_on = sync_q[`AWG_S_SYNC] | coupled;

   // bus handshake: address and data taken in either order, one at a time
   always_comb begin
      st_d     = st_q;
      awa_d    = awa_q;
      wd_d     = wd_q;
      aw_got_d = aw_got_q;
      w_got_d  = w_got_q;
      ws_d     = ws_q;
      rd_d     = rd_q;
      rd_fire  = 1'b0;
      unique case (st_q)
         awg_pkg::ST_IDLE: begin
            if (s_axi_awvalid && !aw_got_q) begin
               awa_d    = s_axi_awaddr;
               aw_got_d = 1'b1;
            end
            if (s_axi_wvalid && !w_got_q) begin
               wd_d    = s_axi_wdata;
               ws_d    = s_axi_wstrb[0];
               w_got_d = 1'b1;
            end
            if (s_axi_arvalid && !aw_got_q && !w_got_q) begin  // arready shown, so ar is taken
               rd_fire = 1'b1;
               st_d    = awg_pkg::ST_RD;
            end else if (aw_got_d && w_got_d) begin
               st_d = awg_pkg::ST_WR;
            end
         end
         awg_pkg::ST_WR: begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            st_d     = awg_pkg::ST_WB;
         end
         awg_pkg::ST_WB: if (s_axi_bready) st_d = awg_pkg::ST_IDLE;
         awg_pkg::ST_RD: if (s_axi_rready) st_d = awg_pkg::ST_IDLE;
      endcase
      if (rd_fire) begin
         unique case (s_axi_araddr)
            `AWG_CTRL0_OFS: rd_d = cfg_word(cfg_q[0]);
            `AWG_CTRL1_OFS: rd_d = cfg_word(cfg_q[1]);
            `AWG_RATE0_OFS: rd_d = par_q[0];
            `AWG_RATE1_OFS: rd_d = par_q[1];
            `AWG_SYNC_OFS:  rd_d = {27'h0, sync_q};
            `AWG_PHASE_OFS: rd_d = {16'h0, phase_q};
            `AWG_STAT0_OFS: rd_d = {28'h0, lderr_q[0], sync_on, once_q[0], play_q[0]};
            `AWG_STAT1_OFS: rd_d = {28'h0, lderr_q[1], sync_on, once_q[1], play_q[1]};
            `AWG_SAMP_OFS:  rd_d = {7'h0, nsamp_q[1], 7'h0, nsamp_q[0]};
            `AWG_LEVEL_OFS: rd_d = {out_q[1], out_q[0]};
            default:        rd_d = 32'h0;
         endcase
      end
      hs_d = {st_d == awg_pkg::ST_RD, st_d == awg_pkg::ST_WB,
              st_d == awg_pkg::ST_IDLE && !aw_got_d && !w_got_d,
              st_d == awg_pkg::ST_IDLE && !w_got_d, st_d == awg_pkg::ST_IDLE && !aw_got_d};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q     <= awg_pkg::ST_IDLE;
         awa_q    <= 8'h0;
         wd_q     <= 32'h0;
         rd_q     <= 32'h0;
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         ws_q     <= 1'b0;
         hs_q     <= 5'h00;
      end else begin
         st_q     <= st_d;
         awa_q    <= awa_d;
         wd_q     <= wd_d;
         rd_q     <= rd_d;
         aw_got_q <= aw_got_d;
         w_got_q  <= w_got_d;
         ws_q     <= ws_d;
         hs_q     <= hs_d;
      end
   end

   assign s_axi_awready = hs_q[0];
   assign s_axi_wready  = hs_q[1];
   assign s_axi_bvalid  = hs_q[3];
   assign s_axi_bresp   = 2'b00;
   assign s_axi_arready = hs_q[2];
   assign s_axi_rvalid  = hs_q[4];
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = 2'b00;

   // effective parameters after coupling
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         eff[g] = par_q[g];
         if (coupled && sync_q[`AWG_S_CPL_FREQ])
            eff[g].rate = par_q[sync_q[`AWG_S_SELECTED]].rate;
         if (coupled && sync_q[`AWG_S_CPL_AMPL])
            eff[g].ampl = par_q[sync_q[`AWG_S_SELECTED]].ampl;
      end
   end

   // register writes, load, and playback
   always_comb begin
      logic       g;
      logic [7:0] a;
      logic       frq;
      logic       c_any;
      g   = wv[`AWG_L_GEN];
      a   = wv[`AWG_L_ADDR_LSB +: 8];
      frq = coupled && sync_q[`AWG_S_CPL_FREQ];
      cfg_d   = cfg_q;
      par_d   = par_q;
      phase_d = phase_q;
      sync_d  = sync_q;
      mem_d   = mem_q;
      nsamp_d = nsamp_q;
      lvl_d   = lvl_q;
      lderr_d = lderr_q;
      trig       = 2'b00;
      single_req = 2'b00;
      c_any      = 1'b0;
      if (wr_fire) begin
         unique case (awa_q)
            `AWG_CTRL0_OFS, `AWG_CTRL1_OFS: begin
               c_any = awa_q[2];
               if (ws_q) begin
                  cfg_d[c_any].run_single = wv[`AWG_C_RUNMODE];
                  cfg_d[c_any].src_saved  = wv[`AWG_C_SOURCE];
                  cfg_d[c_any].out_en     = wv[`AWG_C_OUTEN];
                  single_req[c_any] = wv[`AWG_C_SINGLE];
                  trig[c_any] = wv[`AWG_C_TRIG];
               end
            end
            `AWG_RATE0_OFS: par_d[0] = wv;
            `AWG_RATE1_OFS: par_d[1] = wv;
            `AWG_SYNC_OFS:  if (ws_q) sync_d = wv[4:0];
            `AWG_PHASE_OFS: phase_d = wv[15:0];
            `AWG_LOAD_OFS: begin
               if (cfg_q[g].src_saved) begin
                  mem_d[g][a] = wv[15:0];
                  if (wv[`AWG_L_LAST]) begin
                     nsamp_d[g] = {1'b0, a} + 9'd1;
                     lvl_d[g]   = mem_d[g][0];
                  end
                  lderr_d[g] = 1'b0;
               end else begin
                  lderr_d[g] = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // captured samples only land when the generator sources from capture
      for (int k = 0; k < 2; k++) begin
         if (capt_valid && !cfg_q[k].src_saved) begin
            mem_d[k][capt_addr] = capt_sample;
            nsamp_d[k] = {1'b0, capt_count};
            if (capt_addr == 8'h0) lvl_d[k] = capt_sample;
         end
      end
      // sync start fans a trigger to both generators in one cycle
      if (sync_on && |trig) trig = 2'b11;
      for (int k = 0; k < 2; k++) begin
         if (single_req[k] && (!cfg_q[k].run_single || !cfg_q[k].out_en))
            single_req[k] = 1'b0;
      end
      if (sync_on && |single_req) single_req = 2'b11 & {cfg_q[1].run_single & cfg_q[1].out_en,
                                                       cfg_q[0].run_single & cfg_q[0].out_en};
      play_d = play_q;
      once_d = once_q;
      idx_d  = idx_q;
      div_d  = div_q;
      out_d  = out_q;
      drv_d  = {cfg_q[1].out_en, cfg_q[0].out_en};
      for (int k = 0; k < 2; k++) begin
         logic [8:0] st;
         st = (k == 1 && frq) ? 9'(phase_q % 16'(nsamp_q[1] == 9'd0 ? 16'd1
                                                  : 16'(nsamp_q[1]))) : 9'd0;
         if ((trig[k] || single_req[k]) && nsamp_q[k] != 9'd0) begin
            play_d[k] = 1'b1;
            once_d[k] = cfg_q[k].run_single;
            idx_d[k]  = st;
            div_d[k]  = 16'd0;
         end else if (play_q[k]) begin
            if (div_q[k] + 16'd1 >= eff[k].rate) begin
               div_d[k] = 16'd0;
               if (idx_q[k] + 9'd1 >= nsamp_q[k]) begin
                  idx_d[k] = 9'd0;
                  if (once_q[k]) play_d[k] = 1'b0;
               end else begin
                  idx_d[k] = idx_q[k] + 9'd1;
               end
            end else begin
               div_d[k] = div_q[k] + 16'd1;
            end
         end
         if (play_q[k])
            out_d[k] = scale(mem_q[k][idx_q[k][7:0]], eff[k].ampl);
         else
            out_d[k] = lvl_q[k];
         if (!cfg_q[k].out_en) out_d[k] = 16'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < 2; k++) begin
            cfg_q[k]   <= '0;
            par_q[k]   <= {`AWG_RATE_RST, 16'h0100};
            nsamp_q[k] <= 9'd0;
            lvl_q[k]   <= 16'h0;
            idx_q[k]   <= 9'd0;
            div_q[k]   <= 16'h0;
            out_q[k]   <= 16'h0;
            for (int j = 0; j < D; j++) mem_q[k][j] <= 16'h0;
         end
         phase_q <= 16'h0;
         sync_q  <= 5'h0;
         play_q  <= 2'b00;
         once_q  <= 2'b00;
         lderr_q <= 2'b00;
         drv_q   <= 2'b00;
      end else begin
         cfg_q   <= cfg_d;
         par_q   <= par_d;
         nsamp_q <= nsamp_d;
         lvl_q   <= lvl_d;
         idx_q   <= idx_d;
         div_q   <= div_d;
         out_q   <= out_d;
         mem_q   <= mem_d;
         phase_q <= phase_d;
         sync_q  <= sync_d;
         play_q  <= play_d;
         once_q  <= once_d;
         lderr_q <= lderr_d;
         drv_q   <= drv_d;
      end
   end

   assign generator_one = out_q[0];
   assign generator_two = out_q[1];
   assign gen_drive     = drv_q;
endmodule // awg_top

// [hdl/awg_map.svh]
`ifndef AWG_MAP_SVH
`define AWG_MAP_SVH
// register byte offsets
`define AWG_CTRL0_OFS    8'h00
`define AWG_CTRL1_OFS    8'h04
`define AWG_RATE0_OFS    8'h08
`define AWG_RATE1_OFS    8'h0c
`define AWG_LOAD_OFS     8'h10
`define AWG_SYNC_OFS     8'h14
`define AWG_PHASE_OFS    8'h18
`define AWG_STAT0_OFS    8'h1c
`define AWG_STAT1_OFS    8'h20
`define AWG_SAMP_OFS     8'h24
`define AWG_LEVEL_OFS    8'h28
// ctrl field positions
`define AWG_C_RUNMODE    0
`define AWG_C_SOURCE     1
`define AWG_C_OUTEN      2
`define AWG_C_SINGLE     3
`define AWG_C_TRIG       4
// load register fields
`define AWG_L_DATA_LSB   0
`define AWG_L_ADDR_LSB   16
`define AWG_L_GEN        24
`define AWG_L_LAST       25
`define AWG_L_START      26
// sync register fields
`define AWG_S_SYNC       0
`define AWG_S_CPL_EN     1
`define AWG_S_CPL_FREQ   2
`define AWG_S_CPL_AMPL   3
`define AWG_S_SELECTED   4
// reset value and memory depth
`define AWG_RATE_RST     16'h0001
`define AWG_DEPTH        256
`endif

// [hdl/awg_pkg.sv]
package awg_pkg;
   typedef struct packed {
      logic        run_single;  // 1: single period, 0: continuous
      logic        src_saved;   // 1: saved waveform, 0: captured
      logic        out_en;
   } awg_cfg_t;
   typedef struct packed {
      logic [15:0] rate;        // sample step divider, cycles per sample
      logic [15:0] ampl;        // amplitude gain, 8.8
   } awg_par_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RD   = 4'b0010,
      ST_WR   = 4'b0100,
      ST_WB   = 4'b1000
   } awg_bus_t;
endpackage

// [tb/awg_dut_model.sv]
`timescale 1ns/1ps
// sink standing at a generator output; counts entries into a watched level while driven
module awg_dut_model (
   input  wire logic        aclk,   // sample clock
   input  wire logic [15:0] level,  // converter code seen at the connector
   input  wire logic        drive,  // connector enable
   input  wire logic [15:0] watch,  // level whose arrivals are counted
   input  wire logic        clr,    // clear the arrival count
   output logic      [7:0]  hits    // arrivals since last clear
);
   logic [15:0] prev_q;
   // an undriven connector is not seen by the load, so no arrival counts there
   always_ff @(posedge aclk) begin
      prev_q <= level;
      if (clr)
         hits <= 8'h00;
      else if (drive && level === watch && prev_q !== watch)
         hits <= hits + 8'h01;
   end
endmodule // awg_dut_model

// [tb/awg_top_sva.sv]
`timescale 1ns/1ps
module awg_top_sva (
   input wire logic        aclk,           // clock
   input wire logic        aresetn,        // reset, active low
   input wire logic        s_axi_awvalid,  // write address valid
   input wire logic        s_axi_awready,  // write address ready
   input wire logic        s_axi_wvalid,   // write data valid
   input wire logic        s_axi_wready,   // write data ready
   input wire logic [1:0]  s_axi_bresp,    // write response
   input wire logic        s_axi_bvalid,   // write response valid
   input wire logic        s_axi_bready,   // write response ready
   input wire logic        s_axi_arvalid,  // read address valid
   input wire logic        s_axi_arready,  // read address ready
   input wire logic [31:0] s_axi_rdata,    // read data
   input wire logic [1:0]  s_axi_rresp,    // read response
   input wire logic        s_axi_rvalid,   // read data valid
   input wire logic        s_axi_rready,   // read data ready
   input wire logic [15:0] generator_one,  // code, generator one
   input wire logic [15:0] generator_two,  // code, generator two
   input wire logic [1:0]  gen_drive       // connector enables
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   drive_one_zero_a: assert property (!gen_drive[0] |-> generator_one == 16'h0000)
      else $error("generator one not quiet while its connector is off");
   drive_two_zero_a: assert property (!gen_drive[1] |-> generator_two == 16'h0000)
      else $error("generator two not quiet while its connector is off");
   bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
      else $error("write response not okay");
   rresp_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
      else $error("read response not okay");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held until taken");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !(s_axi_arvalid && s_axi_arready) |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   one_txn_a: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_arready)
      else $error("new request accepted while a response is pending");
   both_on_c: cover property (gen_drive == 2'b11);
   wr_done_c: cover property (s_axi_bvalid && s_axi_bready);
   rd_done_c: cover property (s_axi_rvalid && s_axi_rready);
   offset_c: cover property (generator_one != generator_two);
endmodule // awg_top_sva

bind awg_top awg_top_sva i_awg_top_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .generator_one,
   .generator_two, .gen_drive);

// [tb/tb_awg_top.sv]
`timescale 1ns/1ps
module tb_awg_top;
   logic        aclk, aresetn, clr, capt_valid;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, capt_addr, capt_count, hits;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, gen_drive;
   logic [15:0] capt_sample, generator_one, generator_two, watch;
   int          failures, checks_done, nd;

   awg_top i_awg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .capt_sample, .capt_addr, .capt_valid, .capt_count,
      .generator_one, .generator_two, .gen_drive);
   awg_dut_model i_awg_dut_model (.aclk, .level(generator_one), .drive(gen_drive[0]), .watch,
      .clr, .hits);

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // address and data are offered together and each is dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
         if (!w_ok && s_axi_wready === 1'b1) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask

   task automatic clear;
      @(posedge aclk); clr <= 1'b1;
      @(posedge aclk); clr <= 1'b0;
   endtask

   // four samples 1111..4444, the last one closes the load
   task automatic ld4(input logic gen);
      for (int i = 0; i < 4; i++)
         wr(8'h10, {6'h00, i == 3, gen, 8'(i), 16'(16'h1111 * (i + 1))});
   endtask

   task automatic diff(output int n);
      n = 0;
      repeat (40) begin
         @(posedge aclk);
         if (generator_one !== generator_two) n++;
      end
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      end_sim;
   end

   initial begin
      aresetn = 1'b0; clr = 1'b1; watch = 16'h4444; failures = 0; checks_done = 0;
      s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0; capt_sample = 16'h0; capt_addr = 8'h00; capt_valid = 1'b0;
      capt_count = 8'h00;
      cyc(2);
      aresetn <= 1'b1; clr <= 1'b0;
      rd(8'h08, rv); chk(rv, 32'h00010100);
      wr(8'h08, 32'h00020100); rd(8'h08, rv); chk(rv, 32'h00020100);
      wr(8'h08, 32'h00010100); rd(8'h3c, rv); chk(rv, 32'h0);
      // strobe low must leave the sync register untouched
      s_axi_wstrb <= 4'h0; wr(8'h14, 32'h1f); s_axi_wstrb <= 4'hf;
      rd(8'h14, rv); chk(rv, 32'h0);
      $display("test registers done");
      wr(8'h00, 32'h02); ld4(1'b0);
      rd(8'h24, rv); chk({24'h0, rv[7:0]}, 32'h4);
      wr(8'h00, 32'h06); cyc(3);
      chk({16'h0, generator_one}, 32'h1111);
      chk({30'h0, gen_drive}, 32'h1);
      $display("test load done");
      wr(8'h00, 32'h07); clear; wr(8'h00, 32'h0f); cyc(40);
      chk({24'h0, hits}, 32'h1);
      wr(8'h00, 32'h0f); cyc(40); chk({24'h0, hits}, 32'h2);
      wr(8'h00, 32'h03); clear; wr(8'h00, 32'h0b);
      rd(8'h1c, rv); chk({31'h0, rv[0]}, 32'h0);
      cyc(40); chk({16'h0, generator_one}, 32'h0);
      wr(8'h00, 32'h07); cyc(40); chk({24'h0, hits}, 32'h0);
      wr(8'h00, 32'h06); wr(8'h00, 32'h0e); rd(8'h1c, rv); chk({31'h0, rv[0]}, 32'h0);
      $display("test single done");
      clear; wr(8'h00, 32'h16); cyc(40);
      chk({31'h0, hits >= 8'h02}, 32'h1);
      rd(8'h1c, rv); chk({31'h0, rv[0]}, 32'h1);
      $display("test continuous done");
      wr(8'h00, 32'h04); wr(8'h10, {6'h00, 1'b1, 1'b0, 8'h00, 16'h5555});
      rd(8'h1c, rv); chk({31'h0, rv[3]}, 32'h1);
      rd(8'h24, rv); chk({24'h0, rv[7:0]}, 32'h4);
      capt_count <= 8'h04;
      for (int i = 0; i < 4; i++) begin
         @(posedge aclk);
         capt_valid <= 1'b1; capt_addr <= 8'(i); capt_sample <= 16'(16'h0a01 + i);
      end
      @(posedge aclk); capt_valid <= 1'b0; watch <= 16'h0a04;
      clear; wr(8'h00, 32'h14); cyc(40);
      chk({31'h0, hits >= 8'h02}, 32'h1);
      $display("test source done");
      // gen two gets other rate and gain so only coupling can make the outputs match
      wr(8'h00, 32'h02); wr(8'h04, 32'h02); ld4(1'b0); ld4(1'b1);
      wr(8'h0c, 32'h00030200); wr(8'h04, 32'h06);
      wr(8'h14, 32'h0e); wr(8'h18, 32'h0);
      rd(8'h1c, rv); chk({31'h0, rv[2]}, 32'h1);
      wr(8'h00, 32'h16); diff(nd); chk(32'(nd), 32'h0);
      rd(8'h20, rv); chk({31'h0, rv[0]}, 32'h1);
      wr(8'h00, 32'h02); wr(8'h04, 32'h02); wr(8'h18, 32'h1); wr(8'h04, 32'h06);
      wr(8'h00, 32'h16); diff(nd); chk({31'h0, nd > 0}, 32'h1);
      $display("test coupling done");
      end_sim;
   end
endmodule // tb_awg_top
